// File: include/gbesw_pkg.sv
// constants shared by the word aligner design files
package gbesw_pkg;
  localparam int          WORD_W        = 10;
  localparam int          CNT_W         = 4;
  localparam int          SYNC_W        = 14;
  localparam logic [3:0]  CNT_FIRST     = 4'h0;
  localparam logic [3:0]  CNT_LAST      = 4'h9;
  localparam logic [3:0]  CNT_STEP      = 4'h1;
  localparam logic [9:0]  WORD_ZERO     = 10'h000;
  localparam logic [9:0]  WORD_ONES     = 10'h3FF;
  localparam logic [6:0]  COMMA_VAL     = 7'h7C;
  localparam int          COMMA_LSB     = 0;
  localparam int          COMMA_MSB     = 6;
  localparam logic        SER_IDLE      = 1'b1;
  localparam logic        RXCLK_RST     = 1'b0;
  localparam logic        SIGP_RST      = 1'b0;
  localparam int          SY_REF        = 0;
  localparam int          SY_LOOP       = 1;
  localparam int          SY_ALIGN      = 2;
  localparam int          SY_SERIN      = 3;
  localparam int          SY_DATA       = 4;
endpackage

// File: logic/gbesw_sync.sv
// two flip-flop synchroniser with a constant reset value
`timescale 1ns/100ps
`default_nettype none
module gbesw_sync #(
  parameter int           W       = 1,
  parameter logic         RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta <= {W{RST_VAL}};
      o_q  <= {W{RST_VAL}};
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end
endmodule // gbesw_sync
`default_nettype wire

// File: logic/gbesw_word_align.sv
// serialiser, loopback, comma aligner and recovered byte clocks
// How it works
// - capture transmit word on reference clock rise
// - serialise least significant bit first
// - ten bit times per reference period
// - loopback feeds transmit stream to receiver
// - loopback holds serial output at one
// - comma search realigns word boundary
// - alignment off: no realign, comma low
// - signal present follows threshold comparator
// - two byte clocks launch words alternately
// - comma word launched on clock one
// - receive bit 0 is earliest bit
// - lost signal forces receive word ones
// - comma indication high on comma word
`timescale 1ns/100ps
`default_nettype none
module gbesw_word_align (
  // system clock domain
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // serial bit clock of the link
  input  wire logic       i_bit_clk,
  // transmit side from the host
  input  wire logic       i_tx_ref_clk,
  input  wire logic [9:0] i_tx_word,
  // control pins
  input  wire logic       i_loopback_enable,
  input  wire logic       i_alignment_enable,
  // line side
  input  wire logic       i_serial_in,
  input  wire logic       i_line_above_threshold,
  output logic            o_serial_out,
  // receive side to the host
  output logic [9:0]      o_rx_word,
  output logic            o_rx_byte_clk0,
  output logic            o_rx_byte_clk1,
  output logic            o_comma_indication,
  output logic            o_signal_present
);
  // system domain: threshold comparator
  logic       above_s;
  logic       next_signal_present;

  gbesw_sync #(.W(1), .RST_VAL(1'b0)) u_sync_thr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_d     (i_line_above_threshold),
    .o_q     (above_s)
  );

  always_comb begin
    next_signal_present = above_s;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_signal_present <= gbesw_pkg::SIGP_RST;
    end else begin
      o_signal_present <= next_signal_present;
    end
  end

  // link domain reset, released on the bit clock
  logic bit_rst;

  gbesw_sync #(.W(1), .RST_VAL(1'b1)) u_sync_rst (
    .i_clk   (i_bit_clk),
    .i_reset (i_reset),
    .i_d     (1'b0),
    .o_q     (bit_rst)
  );

  // pins and the signal flag into the link domain
  logic [gbesw_pkg::SYNC_W-1:0] pin_raw;
  logic [gbesw_pkg::SYNC_W-1:0] pin_s;
  logic                         lost_s;
  logic                         ref_s;
  logic                         loop_s;
  logic                         align_s;
  logic                         serin_s;
  logic [9:0]                   data_s;

  assign pin_raw = {i_tx_word, i_serial_in, i_alignment_enable,
                    i_loopback_enable, i_tx_ref_clk};

  gbesw_sync #(.W(gbesw_pkg::SYNC_W), .RST_VAL(1'b0)) u_sync_pins (
    .i_clk   (i_bit_clk),
    .i_reset (bit_rst),
    .i_d     (pin_raw),
    .o_q     (pin_s)
  );

  gbesw_sync #(.W(1), .RST_VAL(1'b1)) u_sync_lost (
    .i_clk   (i_bit_clk),
    .i_reset (bit_rst),
    .i_d     (~o_signal_present),
    .o_q     (lost_s)
  );

  assign ref_s   = pin_s[gbesw_pkg::SY_REF];
  assign loop_s  = pin_s[gbesw_pkg::SY_LOOP];
  assign align_s = pin_s[gbesw_pkg::SY_ALIGN];
  assign serin_s = pin_s[gbesw_pkg::SY_SERIN];
  assign data_s  = pin_s[gbesw_pkg::SY_DATA +: gbesw_pkg::WORD_W];

  // transmit: holding register and serialiser
  logic       ref_d;
  logic       ref_rise;
  logic [9:0] tx_hold;
  logic [9:0] tx_shift;
  logic [3:0] tx_cnt;
  logic       next_ref_d;
  logic [9:0] next_tx_hold;
  logic [9:0] next_tx_shift;
  logic [3:0] next_tx_cnt;
  logic       next_serial_out;

  assign ref_rise = ref_s & ~ref_d;

  always_comb begin
    next_ref_d    = ref_s;
    next_tx_hold  = tx_hold;
    next_tx_shift = {1'b0, tx_shift[9:1]};
    next_tx_cnt   = tx_cnt;
    if (ref_rise) begin
      next_tx_hold  = data_s;
      next_tx_shift = tx_hold;
      next_tx_cnt   = gbesw_pkg::CNT_FIRST;
    end else if (tx_cnt != gbesw_pkg::CNT_LAST) begin
      next_tx_cnt = tx_cnt + gbesw_pkg::CNT_STEP;
    end
    next_serial_out = loop_s ? gbesw_pkg::SER_IDLE : tx_shift[0];
  end

  always_ff @(posedge i_bit_clk or posedge bit_rst) begin
    if (bit_rst) begin
      ref_d        <= 1'b0;
      tx_hold      <= gbesw_pkg::WORD_ZERO;
      tx_shift     <= gbesw_pkg::WORD_ZERO;
      tx_cnt       <= gbesw_pkg::CNT_FIRST;
      o_serial_out <= gbesw_pkg::SER_IDLE;
    end else begin
      ref_d        <= next_ref_d;
      tx_hold      <= next_tx_hold;
      tx_shift     <= next_tx_shift;
      tx_cnt       <= next_tx_cnt;
      o_serial_out <= next_serial_out;
    end
  end

  // receive: deserialiser, comma search and byte clocks
  logic       rx_bit;
  logic [9:0] rx_sr;
  logic [9:0] shifted;
  logic [3:0] rx_cnt;
  logic       rx_sel;
  logic       comma_match;
  logic       word_done;
  logic       launch_sel;
  logic [9:0] next_rx_sr;
  logic [3:0] next_rx_cnt;
  logic       next_rx_sel;
  logic [9:0] next_rx_word;
  logic       next_clk0;
  logic       next_clk1;
  logic       next_comma;

  function automatic logic is_comma(input logic [9:0] w);
    is_comma = (w[gbesw_pkg::COMMA_MSB:gbesw_pkg::COMMA_LSB] == gbesw_pkg::COMMA_VAL);
  endfunction

  assign rx_bit      = loop_s ? tx_shift[0] : serin_s;
  assign shifted     = {rx_bit, rx_sr[9:1]};
  assign comma_match = align_s & is_comma(shifted);
  assign word_done   = (rx_cnt == gbesw_pkg::CNT_LAST) | comma_match;
  assign launch_sel  = comma_match ? 1'b1 : rx_sel;

  always_comb begin
    next_rx_sr   = shifted;
    next_rx_cnt  = rx_cnt + gbesw_pkg::CNT_STEP;
    next_rx_sel  = rx_sel;
    next_rx_word = o_rx_word;
    next_clk0    = o_rx_byte_clk0;
    next_clk1    = o_rx_byte_clk1;
    next_comma   = o_comma_indication;
    if (word_done) begin
      next_rx_cnt  = gbesw_pkg::CNT_FIRST;
      next_rx_sel  = ~launch_sel;
      next_rx_word = lost_s ? gbesw_pkg::WORD_ONES : shifted;
      next_clk0    = ~launch_sel;
      next_clk1    = launch_sel;
      next_comma   = comma_match;
    end
    if (!align_s) begin
      next_comma = 1'b0;
    end
  end

  always_ff @(posedge i_bit_clk or posedge bit_rst) begin
    if (bit_rst) begin
      rx_sr              <= gbesw_pkg::WORD_ZERO;
      rx_cnt             <= gbesw_pkg::CNT_FIRST;
      rx_sel             <= 1'b0;
      o_rx_word          <= gbesw_pkg::WORD_ONES;
      o_rx_byte_clk0     <= gbesw_pkg::RXCLK_RST;
      o_rx_byte_clk1     <= gbesw_pkg::RXCLK_RST;
      o_comma_indication <= 1'b0;
    end else begin
      rx_sr              <= next_rx_sr;
      rx_cnt             <= next_rx_cnt;
      rx_sel             <= next_rx_sel;
      o_rx_word          <= next_rx_word;
      o_rx_byte_clk0     <= next_clk0;
      o_rx_byte_clk1     <= next_clk1;
      o_comma_indication <= next_comma;
    end
  end

  // assertion arm: set one link clock after the link reset lets go
  logic chk_arm;
  logic next_chk_arm;

  always_comb begin
    next_chk_arm = 1'b1;
  end

  always_ff @(posedge i_bit_clk or posedge bit_rst) begin
    if (bit_rst) begin
      chk_arm <= 1'b0;
    end else begin
      chk_arm <= next_chk_arm;
    end
  end

  // checks
  sequence s_load_word;
    ref_rise ##1 (tx_shift == $past(tx_hold));
  endsequence

  sequence s_shift_once;
    (tx_shift[8:0] == $past(tx_shift[9:1]));
  endsequence

  a_signal_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    ##1 (o_signal_present == $past(above_s)))
    else $error("signal present does not follow comparator");

  a_tx_capture: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    ref_rise |=> (tx_hold == $past(data_s)))
    else $error("transmit word not captured on reference rise");

  a_lsb_first: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    s_load_word |=> s_shift_once)
    else $error("transmit word not shifted out low bit first");

  a_bit_count: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (!ref_rise && tx_cnt != gbesw_pkg::CNT_LAST) |=> (tx_cnt == $past(tx_cnt) + 4'h1))
    else $error("bit counter did not advance");

  a_loop_route: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    loop_s |=> (rx_sr[9] == $past(tx_shift[0])))
    else $error("loopback did not route transmit bit to receiver");

  a_loop_static: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    loop_s |=> o_serial_out)
    else $error("serial output not static one in loopback");

  a_normal_out: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    !loop_s |=> (o_serial_out == $past(tx_shift[0])))
    else $error("serial output not driven from serialiser");

  a_realign: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    comma_match |=> (rx_cnt == 4'h0) ##9 (rx_cnt == 4'h9))
    else $error("word boundary not realigned to comma");

  a_no_align: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    !align_s |=> !o_comma_indication)
    else $error("comma indication high with alignment off");

  a_clk_alternate: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    word_done |=> ((o_rx_byte_clk0 ^ o_rx_byte_clk1)
                   && ($past(comma_match) || (o_rx_byte_clk0 != $past(o_rx_byte_clk0)))))
    else $error("byte clocks do not alternate");

  a_comma_clk1: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    comma_match |=> (o_rx_byte_clk1 && !o_rx_byte_clk0 && o_comma_indication))
    else $error("comma word not launched on byte clock one");

  a_word_order: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (word_done && !lost_s) |=> (o_rx_word == {$past(rx_bit), $past(rx_sr[9:1])}))
    else $error("receive word bit order wrong");

  a_lost_ones: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (word_done && lost_s) |=> (o_rx_word == 10'h3FF))
    else $error("receive word not all ones on lost signal");

  a_comma_hold: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (o_comma_indication && !word_done && align_s) |=> o_comma_indication)
    else $error("comma indication dropped inside its word");

  a_comma_single: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (word_done && !comma_match) |=> !o_comma_indication)
    else $error("comma indication outlived its word");

  a_comma_word: assert property (@(posedge i_bit_clk) disable iff (!chk_arm)
    (comma_match && !lost_s) |=>
      (o_rx_word[gbesw_pkg::COMMA_MSB:gbesw_pkg::COMMA_LSB] == gbesw_pkg::COMMA_VAL))
    else $error("comma indication without comma word");
endmodule // gbesw_word_align
`default_nettype wire

// File: test/gbesw_host_model.sv
// host side model: reference byte clock and coded transmit words
`timescale 1ns/100ps
`default_nettype none
module gbesw_host_model (
  // link clock and reset
  input  wire logic       i_bit_clk,
  input  wire logic       i_reset,
  // transmit side
  output logic            o_tx_ref_clk,
  output logic [9:0]      o_tx_word
);
  logic [3:0] cnt;
  // reference is one tenth of the bit clock; words change at its fall
  always_ff @(posedge i_bit_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt          <= 4'h0;
      o_tx_ref_clk <= 1'b0;
      o_tx_word    <= 10'h27C;
    end else begin
      cnt          <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
      o_tx_ref_clk <= (cnt < 4'h4) || (cnt == 4'h9);
      if (cnt == 4'h4) begin
        // comma word and data word alternate, both already coded
        o_tx_word <= (o_tx_word == 10'h27C) ? 10'h155 : 10'h27C;
      end
    end
  end
endmodule // gbesw_host_model
`default_nettype wire

// File: test/tb_gbe_serdes_word_align.sv
// testbench for the word aligner
`timescale 1ns/100ps
`default_nettype none
module tb_gbe_serdes_word_align;
  logic       clk, rst, bit_clk, ref_clk, loop, align, ser_in, above;
  logic       ser_out, bc0, bc1, comma, sigp;
  logic [9:0] word, rx_word, sh;
  int         bad_count, n_tests;

  gbesw_host_model gbesw_host_model_i (.i_bit_clk(bit_clk), .i_reset(rst),
    .o_tx_ref_clk(ref_clk), .o_tx_word(word));

  gbesw_word_align gbesw_word_align_i (.i_clk(clk), .i_reset(rst), .i_bit_clk(bit_clk),
    .i_tx_ref_clk(ref_clk), .i_tx_word(word), .i_loopback_enable(loop),
    .i_alignment_enable(align), .i_serial_in(ser_in), .i_line_above_threshold(above),
    .o_serial_out(ser_out), .o_rx_word(rx_word), .o_rx_byte_clk0(bc0),
    .o_rx_byte_clk1(bc1), .o_comma_indication(comma), .o_signal_present(sigp));

  always #25 clk = ~clk;
  always #16 bit_clk = ~bit_clk;

  // external line loop and a window of the serial output, earliest bit in bit 0
  always @(posedge bit_clk) begin
    ser_in <= ser_out;
    sh     <= {ser_out, sh[9:1]};
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? comma : (s == 1) ? bc0 : (sh === 10'h27C);
  endfunction

  task automatic wait_for(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 400) begin
      @(posedge bit_clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic wait_rise(input int s);
    wait_for(s, 1'b0);
    wait_for(s, 1'b1);
  endtask

  task automatic bits(input int n);
    repeat (n) @(posedge bit_clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    stop_test();
  end

  initial begin
    logic hit;
    clk = 1'b0;
    bit_clk = 1'b0;
    rst = 1'b1;
    loop = 1'b1;
    align = 1'b1;
    above = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bits(60);
    // loopback with alignment: comma word lands on byte clock one
    wait_rise(0);
    chk(rx_word, 10'h27C);
    chk({bc1, bc0}, 2'b10);
    chk(ser_out, 1'b1);
    wait_rise(1);
    chk(rx_word, 10'h155);
    chk({comma, bc1}, 2'b00);
    // alignment off: comma never raised
    @(posedge clk);
    align <= 1'b0;
    bits(10);
    hit = 1'b0;
    repeat (60) begin
      bits(1);
      if (comma !== 1'b0) hit = 1'b1;
    end
    chk(hit, 1'b0);
    // normal line: serial output lsb first, external input received
    @(posedge clk);
    align <= 1'b1;
    loop <= 1'b0;
    wait_for(2, 1'b1);
    chk(sh, 10'h27C);
    bits(30);
    wait_rise(0);
    chk(rx_word, 10'h27C);
    chk(bc1, 1'b1);
    // signal loss forces all ones, then recovers
    @(posedge clk);
    above <= 1'b0;
    bits(20);
    chk(sigp, 1'b0);
    wait_rise(1);
    chk(rx_word, 10'h3FF);
    @(posedge clk);
    above <= 1'b1;
    bits(20);
    chk(sigp, 1'b1);
    stop_test();
  end
endmodule // tb_gbe_serdes_word_align
`default_nettype wire
